// ### src/cfg_link_device.sv
// converter configuration decoder: captures 16-bit serial frames into the
// control and range registers and presents the decoded configuration.
// assumes link pins are asynchronous to pclk and sclk is slower than pclk/4.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_link_params.svh"
module cfg_link_device (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    cfg_link_if.device                      link,
    input  wire logic                       conv_start,
    output logic [`CTRL_W-1:0]              conversion_control,
    output logic [`RANGE_W-1:0]             range_r,
    output logic                            channel_select_bit,
    output cfg_link_pkg::input_cfg_t        input_cfg,
    output cfg_link_pkg::power_mode_t       power_mode,
    output logic                            coding_binary,
    output logic                            ref_internal,
    output logic                            sequence_on,
    output logic                            seq_channel,
    output logic [1:0]                      route_pos,
    output logic [1:0]                      route_neg,
    output logic                            low_power,
    output logic                            frame_error
);
    import cfg_link_pkg::*;

    // each link pin passes two flip-flops before any logic reads it
    logic sclk_s;
    logic frame_s;
    logic din_s;
    pin_sync #(
        .IDLE (1'b1)
    ) sclk_sync_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (link.sclk),
        .sync_r  (sclk_s)
    );
    pin_sync #(
        .IDLE (1'b1)
    ) frame_sync_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (link.frame_n),
        .sync_r  (frame_s)
    );
    pin_sync #(
        .IDLE (1'b0)
    ) din_sync_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (link.din),
        .sync_r  (din_s)
    );

    // one more stage for edge finding; frame_n is delayed alike so the
    // sixteenth rise, which comes together with frame_n high, still counts
    logic sclk_d_r;
    logic frame_d_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d_r  <= 1'b1; // idle level, so no false edge after reset
            frame_d_r <= 1'b1;
        end else begin
            sclk_d_r  <= sclk_s;
            frame_d_r <= frame_s;
        end
    end

    wire rise      = sclk_s & ~sclk_d_r;
    wire in_frame  = ~frame_d_r;
    wire take_bit  = rise & in_frame;

    // shift register and edge count
    logic [`FRAME_BITS-1:0] shift_r;
    logic [4:0]             cnt_r;
    wire  [`FRAME_BITS-1:0] shift_nxt = {shift_r[`FRAME_BITS-2:0], din_s};
    wire  [4:0]             cnt_nxt   = cnt_r + 5'h01;
    wire                    last_bit  = take_bit && cnt_nxt == 5'(`FRAME_BITS);

    // header decode on the full frame
    wire hdr_write = shift_nxt[`POS_WRITE];
    wire hdr_zero  = shift_nxt[`POS_ZERO];
    wire hdr_sel   = shift_nxt[`POS_SEL];
    wire load_ctrl = last_bit & hdr_write & ~hdr_sel;
    wire load_rng  = last_bit & hdr_write & hdr_sel;
    // low-power entry when a pending update lands on edge 15
    wire edge15    = take_bit && cnt_nxt == 5'(`LOWPWR_EDGE);
    wire [1:0] pm_in = shift_nxt[`CF_PM_HI-1:`CF_PM_LO-1];
    wire hit_lp15  = edge15 & shift_nxt[`POS_WRITE-1] & ~shift_nxt[`POS_SEL-1]
                     & (pm_in == 2'h1 || pm_in == 2'h2);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r <= 16'h0000;
            cnt_r   <= 5'h00;
        end else if (!in_frame) begin
            cnt_r   <= 5'h00;
        end else if (take_bit) begin
            shift_r <= shift_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // registers: no path reads them back onto the link
    logic [`CTRL_W-1:0] ctrl_active_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_control <= `CTRL_RESET;
            range_r            <= `RANGE_RESET;
            ctrl_active_r      <= `CTRL_RESET;
            frame_error        <= 1'b0;
            low_power          <= 1'b0;
        end else begin
            // full shutdown has no clear path, contents stay
            if (load_ctrl)
                conversion_control <= shift_nxt[`CTRL_HI-1:0];
            if (load_rng)
                range_r <= shift_nxt[`RANGE_HI:`RANGE_LO];
            // staged value only applies at the next conversion start
            if (conv_start)
                ctrl_active_r <= conversion_control;
            if (last_bit)
                frame_error <= hdr_zero; // flags a host breaking the zero bit
            if (hit_lp15)
                low_power <= 1'b1;
            else if (load_ctrl && shift_nxt[`CF_PM_HI:`CF_PM_LO] == 2'h0)
                low_power <= 1'b0;
        end
    end

    // decoded view of the active configuration
    wire        a_chan = ctrl_active_r[`CF_CHAN];
    wire [1:0]  a_mode = ctrl_active_r[`CF_MODE_HI:`CF_MODE_LO];
    wire [1:0]  a_pm   = ctrl_active_r[`CF_PM_HI:`CF_PM_LO];
    wire        a_seq  = ctrl_active_r[`CF_SEQ_A] & ~ctrl_active_r[`CF_SEQ_B];
    wire [1:0]  pos_w  = (a_mode == 2'h0 && a_chan) ? 2'h1 : 2'h0;
    wire [1:0]  neg_w  = (a_mode == 2'h0) ? 2'h2 : 2'h1; // 2 = analog_ground

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_select_bit <= 1'b0;
            input_cfg          <= INCFG_SINGLE;
            power_mode         <= PWR_NORMAL;
            coding_binary      <= 1'b0;
            ref_internal       <= 1'b0;
            sequence_on        <= 1'b0;
            seq_channel        <= 1'b0;
            route_pos          <= 2'h0;
            route_neg          <= 2'h2;
        end else begin
            channel_select_bit <= a_chan;
            input_cfg          <= input_cfg_t'(a_mode);
            power_mode         <= power_mode_t'(a_pm);
            coding_binary      <= ctrl_active_r[`CF_CODING];
            ref_internal       <= ctrl_active_r[`CF_REF];
            sequence_on        <= a_seq;
            seq_channel        <= a_seq & a_chan; // last channel of sequence
            route_pos          <= pos_w;
            route_neg          <= neg_w;
        end
    end
endmodule : cfg_link_device

// two-flop synchroniser for one pin from outside the pclk domain;
// resets to the pin's idle level so the first edges after reset are real
module pin_sync #(
    parameter logic IDLE = 1'b0
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      sync_r
);
    logic meta_r;
    // only the second stage leaves this module
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= IDLE;
            sync_r <= IDLE;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ### src/cfg_link_host.sv
// host end: APB slave takes a 16-bit frame order and shifts it out on the link
// assumes APB master on pclk; sclk derived by divider from pclk
`timescale 1ns/1ps
`default_nettype none
`include "cfg_link_params.svh"
module cfg_link_host (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    cfg_link_if.host           link
);
    import cfg_link_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} host_state_t;
    host_state_t            state_r;
    logic [`FRAME_BITS-1:0] frame_r;
    logic [15:0]            last_r;
    logic [4:0]             bits_r;
    logic [2:0]             div_r;

    // apb decode; a wait-state-free slave, pready high in access
    wire acc       = psel & penable;
    wire hit_cmd   = paddr == `REG_CMD;
    wire hit_stat  = paddr == `REG_STATUS;
    wire hit_rdat  = paddr == `REG_RDATA;
    wire busy      = state_r != ST_IDLE;
    wire go        = acc & pwrite & hit_cmd & ~busy & pwdata[`CMD_GO_BIT];
    // orders while busy are refused with pslverr
    wire bad       = acc & ((~hit_cmd & ~hit_stat & ~hit_rdat) | (pwrite & ~hit_cmd) | (pwrite & busy));
    wire div_end   = div_r == 3'(`SCLK_DIV - 1);
    // zero bit forced low regardless of software
    wire [15:0] frame_in = {pwdata[15], 1'b0, pwdata[13:0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            frame_r <= 16'h0000;
            last_r  <= 16'h0000;
            bits_r  <= 5'h00;
            div_r   <= 3'h0;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            link.sclk    <= 1'b1;
            link.frame_n <= 1'b1;
            link.din     <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (acc && pready)
                pslverr <= 1'b0;
            if (psel && !penable)
                prdata <= hit_stat ? {31'h0, busy} : hit_rdat ? {16'h0, last_r} : 32'h0;
            if (psel && penable && !pready)
                pslverr <= 1'b0;
            if (psel && !penable)
                pslverr <= 1'b0;
            if (bad && !pready)
                pslverr <= 1'b0;
            if (psel && !penable && (busy && pwrite || !(paddr == `REG_CMD || paddr == `REG_STATUS
                || paddr == `REG_RDATA) || (pwrite && paddr != `REG_CMD)))
                pslverr <= 1'b1;
            case (state_r)
                ST_IDLE: begin
                    if (go && pready) begin
                        frame_r      <= frame_in;
                        last_r       <= frame_in;
                        bits_r       <= 5'h00;
                        div_r        <= 3'h0;
                        link.frame_n <= 1'b0;
                        link.din     <= frame_in[`FRAME_BITS-1];
                        state_r      <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    div_r <= div_end ? 3'h0 : div_r + 3'h1;
                    if (div_end) begin
                        link.sclk <= 1'b0;
                        state_r   <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    div_r <= div_end ? 3'h0 : div_r + 3'h1;
                    if (div_end) begin
                        link.sclk <= 1'b1; // device samples this rising edge
                        bits_r    <= bits_r + 5'h01;
                        frame_r   <= {frame_r[`FRAME_BITS-2:0], 1'b0};
                        if (bits_r == 5'(`FRAME_BITS - 1)) begin
                            link.frame_n <= 1'b1;
                            state_r      <= ST_IDLE;
                        end else begin
                            state_r <= ST_LOW;
                        end
                    end
                    if (div_r == 3'h2 && bits_r != 5'h00)
                        link.din <= frame_r[`FRAME_BITS-1];
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule : cfg_link_host
`default_nettype wire

// ### src/cfg_link_if.sv
// serial config link: host drives clock, frame and data-in
// assumes both ends are clocked by their own pclk
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
    logic sclk;      // link clock, idle high
    logic frame_n;   // low over the 16-bit frame
    logic din;       // data-in, msb first
    modport host   (output sclk, output frame_n, output din);
    modport device (input  sclk, input  frame_n, input  din);
endinterface : cfg_link_if
`default_nettype wire

// ### src/cfg_link_params.svh
// timing counts, field positions and reset values for the converter config link
// included by the package and both ends; definitions only
`ifndef CFG_LINK_PARAMS_SVH
`define CFG_LINK_PARAMS_SVH

`define FRAME_BITS        16
`define POS_WRITE         15
`define POS_ZERO          14
`define POS_SEL           13
`define CTRL_HI           12
`define CTRL_W            12
`define RANGE_HI          12
`define RANGE_LO          7
`define RANGE_W           6
`define CTRL_RESET        12'h000
`define RANGE_RESET       6'h00
`define LOWPWR_EDGE       15
`define CF_CHAN           10
`define CF_MODE_HI        9
`define CF_MODE_LO        8
`define CF_PM_HI          7
`define CF_PM_LO          6
`define CF_CODING         5
`define CF_REF            4
`define CF_SEQ_A          3
`define CF_SEQ_B          2
`define SCLK_DIV          6
`define REG_CMD           12'h000
`define REG_STATUS        12'h004
`define REG_RDATA         12'h008
`define CMD_GO_BIT        16

`endif

// ### src/cfg_link_pkg.sv
// types shared by both ends of the converter configuration link
// assumes cfg_link_params.svh on the include path
`default_nettype none
`include "cfg_link_params.svh"
package cfg_link_pkg;
    typedef enum logic [1:0] {
        INCFG_SINGLE, INCFG_PSEUDO, INCFG_DIFF, INCFG_FORBIDDEN
    } input_cfg_t;
    typedef enum logic [1:0] {
        PWR_NORMAL, PWR_AUTOSTANDBY, PWR_AUTOSHUTDOWN, PWR_FULL_SHUTDOWN
    } power_mode_t;
    typedef enum logic [1:0] {
        RANGE_PM10, RANGE_PM5, RANGE_PM2P5, RANGE_0TO10
    } range_code_t;
endpackage : cfg_link_pkg
`default_nettype wire

// ### testbench/cfg_link_props.sv
// checker for the serial config wire between host end and device end
// assumes sclk idles high and both ends run on pclk
`timescale 1ns/1ps
`default_nettype none
module cfg_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sclk,
    input wire logic frame_n,
    input wire logic din
);
    logic       sclk_q_r;
    logic       frame_q_r;
    logic [4:0] rise_cnt_r;
    logic       rise;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // rising sclk edges; the closing one lands with frame_n high
    assign rise = sclk & ~sclk_q_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q_r <= 1'b1;
            frame_q_r <= 1'b1;
            rise_cnt_r <= 5'h00;
        end else begin
            sclk_q_r <= sclk;
            frame_q_r <= frame_n;
            if (rise && !frame_q_r) begin
                rise_cnt_r <= rise_cnt_r + 5'h01;
            end else if (frame_n) begin
                rise_cnt_r <= 5'h00;
            end
        end
    end
    AST_IDLE_HIGH: assert property (frame_n && frame_q_r |-> sclk)
        else $error("sclk moved outside a frame");
    AST_FRAME_LEN: assert property ($rose(frame_n) |-> rise && rise_cnt_r == 5'd15)
        else $error("frame did not close on the sixteenth rise");
    AST_RISE_MAX: assert property (rise_cnt_r <= 5'd16)
        else $error("too many sclk rises in a frame");
    AST_ZERO_BIT: assert property (rise && !frame_n && rise_cnt_r == 5'd1 |-> !din)
        else $error("second frame bit not zero");
    AST_DIN_HOLD: assert property (rise && !frame_n |-> $stable(din) ##1 $stable(din))
        else $error("din moved around a sampling rise");
    AST_LOW_SPAN: assert property ($fell(sclk) |-> !sclk [*6] ##1 sclk)
        else $error("sclk low phase wrong length");
    AST_HIGH_SPAN: assert property (rise && !frame_n |-> sclk [*6] ##1 !sclk)
        else $error("sclk high phase wrong length");
    AST_START: assert property ($fell(frame_n) |-> sclk ##[1:12] $fell(sclk))
        else $error("no clock after frame start");
endmodule : cfg_link_props
`default_nettype wire

// ### testbench/tb.sv
// bench: host end ordered over APB, device end decoding across the link
// assumes both ends share pclk; wire timing judged by cfg_link_props
`timescale 1ns/1ps
`default_nettype none
`include "cfg_link_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
$display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
    import cfg_link_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_start = 0;
    logic [11:0] paddr = 12'h000, ctrl;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, chan, coding_binary, ref_internal, sequence_on, seq_channel;
    logic low_power, frame_error;
    logic [5:0] range_r;
    logic [1:0] route_pos, route_neg;
    input_cfg_t input_cfg;
    power_mode_t power_mode;
    logic [15:0] cap;
    logic [4:0] ncap;
    logic sclk_q = 1, fr_q = 1;
    int bad_count = 0, comparisons = 0;
    cfg_link_if link_bus ();
    cfg_link_host cfg_link_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link_bus));
    cfg_link_device cfg_link_device_inst (.pclk(pclk), .presetn(presetn), .link(link_bus),
        .conv_start(conv_start), .conversion_control(ctrl), .range_r(range_r),
        .channel_select_bit(chan), .input_cfg(input_cfg), .power_mode(power_mode),
        .coding_binary(coding_binary), .ref_internal(ref_internal), .sequence_on(sequence_on),
        .seq_channel(seq_channel), .route_pos(route_pos), .route_neg(route_neg),
        .low_power(low_power), .frame_error(frame_error));
    cfg_link_props cfg_link_props_inst (.pclk(pclk), .presetn(presetn), .sclk(link_bus.sclk),
        .frame_n(link_bus.frame_n), .din(link_bus.din));
    initial forever #5 pclk = ~pclk;
    // wire capture; the last bit lands as frame_n rises, so judge by the old frame_n
    always @(posedge pclk) begin
        sclk_q <= link_bus.sclk;
        fr_q <= link_bus.frame_n;
        if (!link_bus.frame_n && fr_q) ncap <= 5'd0;
        else if (link_bus.sclk && !sclk_q && !fr_q) begin
            cap <= {cap[14:0], link_bus.din};
            ncap <= ncap + 5'd1;
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        `CHK(n < 50, 1'b1)
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    // order one frame, poll busy, then judge what crossed the wire
    task automatic send(input logic [15:0] f);
        int n = 0;
        apb(1, `REG_CMD, {15'h0, 1'b1, f});
        `CHK(err, 1'b0)
        do begin
            apb(0, `REG_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 100);
        `CHK(n < 100, 1'b1)
        repeat (8) @(posedge pclk);
        `CHK(ncap, 5'd16)
        `CHK(cap, f & 16'hBFFF)
    endtask : send
    task automatic conv();
        conv_start <= 1;
        @(posedge pclk);
        conv_start <= 0;
        repeat (3) @(posedge pclk);
    endtask : conv
    function automatic logic [15:0] cf(input logic c, input logic [1:0] md, pm, input logic cd, rf, sa, sb);
        cf = {4'h8, 1'b0, c, md, pm, cd, rf, sa, sb, 2'b00};
    endfunction : cf
    task automatic t_regs();
        `CHK(ctrl, 12'h000)
        `CHK(range_r, 6'h00)
        `CHK(route_neg, 2'h2)
        send({3'b101, 6'h1B, 7'h00});
        `CHK(range_r, 6'h1B)
        `CHK(ctrl, 12'h000)
        send(cf(1, 0, 0, 1, 1, 0, 0));
        `CHK(ctrl, 12'h430)
        `CHK(coding_binary, 1'b0)
        conv();
        `CHK(coding_binary, 1'b1)
        `CHK(ref_internal, 1'b1)
        send(16'h3FFF);
        `CHK(ctrl, 12'h430)
        `CHK(range_r, 6'h1B)
        $display("register test done");
    endtask : t_regs
    task automatic t_routes();
        for (int m = 0; m < 3; m++) for (int c = 0; c < 2; c++) begin
            send(cf(1'(c), 2'(m), 0, 0, 0, 0, 0));
            conv();
            `CHK(input_cfg, input_cfg_t'(m))
            `CHK(chan, 1'(c))
            `CHK(route_pos, (m == 0) ? 2'(c) : 2'h0)
            `CHK(route_neg, (m == 0) ? 2'h2 : 2'h1)
        end
        $display("routing test done");
    endtask : t_routes
    task automatic t_seq();
        for (int k = 0; k < 4; k++) begin
            send(cf(1, 0, 0, 0, 0, k[1], k[0]));
            conv();
            `CHK(ctrl[3:2], 2'(k))
            `CHK(sequence_on, k == 2)
            `CHK(seq_channel, k == 2)
        end
        $display("sequencer test done");
    endtask : t_seq
    task automatic t_power();
        logic [1:0] pms[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        for (int i = 0; i < 4; i++) begin
            send(cf(0, 0, pms[i], 0, 0, 0, 0));
            `CHK(low_power, i < 3)
            conv();
            `CHK(power_mode, power_mode_t'(pms[i]))
            if (i == 2) begin
                send(16'h0000);
                `CHK(ctrl, 12'h0C0)
            end
        end
        $display("power test done");
    endtask : t_power
    // refusals: busy order, unmapped read, status write; readback of last frame
    task automatic t_apb();
        apb(1, `REG_CMD, 32'h1_8000);
        apb(1, `REG_CMD, 32'h1_8000);
        `CHK(err, 1'b1)
        repeat (300) @(posedge pclk);
        apb(0, `REG_RDATA, 32'h0);
        `CHK(q[15:0], 16'h8000)
        apb(0, 12'h00C, 32'h0);
        `CHK(err, 1'b1)
        apb(1, `REG_STATUS, 32'h1);
        `CHK(err, 1'b1)
        `CHK(frame_error, 1'b0)
        $display("bus test done");
    endtask : t_apb
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_regs();
        t_routes();
        t_seq();
        t_power();
        t_apb();
        final_report();
    end
    // watchdog, roughly twenty times the expected run
    initial begin
        #800000;
        bad_count++;
        final_report();
    end
endmodule : tb
`default_nettype wire
